/* rtl/bfd_top.sv */
// fault handling and gate sequencing for a two-phase bridge driver
`timescale 1ns/10ps
`include "bfd_defs.svh"
module bfd_top (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input bfd_pkg::bfd_phase_cmd_t phase_a_cmd_i,
    input bfd_pkg::bfd_phase_cmd_t phase_b_cmd_i,
    input wire logic sleep_clear_n_i,
    input wire logic overtemp_i,
    input wire logic gate_supply_below_falling_i,
    input wire logic gate_supply_above_rising_i,
    input wire logic logic_supply_low_i,
    input wire logic [1:0] boot_ok_i,
    input wire logic [1:0] boot_low_i,
    input wire logic charge_pump_ready_i,
    input wire logic [1:0] dead_interval_select_i,
    input wire logic [`BFD_CNT_W-1:0] dead_ext_cyc_i,
    output bfd_pkg::bfd_phase_gate_t phase_a_gate_o,
    output bfd_pkg::bfd_phase_gate_t phase_b_gate_o,
    output logic fault_n_o,
    output logic fault_n_oe_o,
    output logic sleep_o
);
    import bfd_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NS = 16;
    logic [NS-1:0] raw;
    logic [NS-1:0] syn;
    assign raw = {phase_a_cmd_i, phase_b_cmd_i, sleep_clear_n_i, overtemp_i,
                  gate_supply_below_falling_i, gate_supply_above_rising_i,
                  logic_supply_low_i, boot_ok_i, boot_low_i,
                  charge_pump_ready_i, dead_interval_select_i};
    bfd_sync2 #(.W(NS)) u_sync (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .async_i(raw),
        .sync_o(syn)
    );
    bfd_phase_cmd_t a_cmd;
    bfd_phase_cmd_t b_cmd;
    logic clr_n;
    logic ot;
    logic gs_low;
    logic gs_ok;
    logic ls_low;
    logic [1:0] b_ok;
    logic [1:0] b_low;
    logic cp_rdy;
    logic [1:0] dsel;
    assign {a_cmd, b_cmd, clr_n, ot, gs_low, gs_ok, ls_low, b_ok, b_low,
            cp_rdy, dsel} = syn;

    // ------------------------------------------------------------
    // fault state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] cmd_q;
        logic gs_fault;
        logic boot_fault;
        logic [`BFD_CNT_W-1:0] clr_cnt;
        logic [`BFD_CNT_W-1:0] wake_cnt;
        logic awake;
        logic fault_n;
        logic sleep;
    } bfd_top_st_t;
    bfd_top_st_t st_r;
    bfd_top_st_t st_nxt;
    logic [1:0] boot_to;
    logic any_rise;
    logic clr_pulse;
    logic enable;
    logic dead_on;
    logic [`BFD_CNT_W-1:0] dead_cyc;

    always_comb begin
        st_nxt = st_r;
        st_nxt.cmd_q = {a_cmd, b_cmd};
        any_rise = |({a_cmd, b_cmd} & ~st_r.cmd_q);
        st_nxt.sleep = ~clr_n;
        // clear pulse counter: long-enough low clears latches
        if (clr_n) begin
            st_nxt.clr_cnt = '0;
        end else if (st_r.clr_cnt != `BFD_CNT_W'(`BFD_CLEAR_CYC)) begin
            st_nxt.clr_cnt = st_r.clr_cnt + 1'b1;
        end
        clr_pulse = ~clr_n
            & (st_r.clr_cnt + 1'b1 >= `BFD_CNT_W'(`BFD_CLEAR_CYC));
        // gate supply fault: set wins over a command-edge or clear-pulse clear
        if (gs_low || (st_r.gs_fault && !gs_ok)) begin
            st_nxt.gs_fault = 1'b1;
        end else if (any_rise || clr_pulse) begin
            st_nxt.gs_fault = 1'b0;
        end
        if (|boot_to) begin
            st_nxt.boot_fault = 1'b1;
        end else if (any_rise || !clr_n) begin
            st_nxt.boot_fault = 1'b0;
        end
        if (ls_low) begin
            // logic supply drop clears the latched gate supply and bootstrap faults
            st_nxt.gs_fault = 1'b0;
            st_nxt.boot_fault = 1'b0;
        end
        // wake delay after sleep for charge pump
        if (!clr_n) begin
            st_nxt.awake = 1'b0;
            st_nxt.wake_cnt = '0;
        end else if (cp_rdy && st_r.wake_cnt >=
                     `BFD_CNT_W'(`BFD_CP_WAKE_CYC)) begin
            st_nxt.awake = 1'b1;
        end else if (st_r.wake_cnt != '1) begin
            st_nxt.wake_cnt = st_r.wake_cnt + 1'b1;
        end
        // overtemp only flags, disables nothing
        st_nxt.fault_n = ~(ot | ls_low | st_nxt.gs_fault
                           | st_nxt.boot_fault);
    end

    // outputs disabled on any disabling fault
    assign enable = clr_n & st_r.awake & ~ls_low & ~st_r.gs_fault
                    & ~st_r.boot_fault;

    // dead-interval mode: strapped max, external, or off
    always_comb begin
        dead_on = 1'b1;
        dead_cyc = dead_ext_cyc_i;
        case (dsel)
            `BFD_DSEL_OFF: dead_on = 1'b0;
            `BFD_DSEL_MAX: dead_cyc = `BFD_CNT_W'(`BFD_DEAD_MAX_CYC);
            default: dead_cyc = dead_ext_cyc_i;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            // power-up: gate supply fault set until rising limit seen, then cleared by a command edge or clear pulse
            st_r <= '{gs_fault: 1'b1, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // phases; braking combos pass through directly when the dead interval is off
    // ------------------------------------------------------------
    bfd_phase u_pha (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .cmd_i(a_cmd),
        .boot_ok_i(b_ok[1]),
        .boot_low_i(b_low[1]),
        .enable_i(enable),
        .dead_on_i(dead_on),
        .dead_cyc_i(dead_cyc),
        .gate_o(phase_a_gate_o),
        .boot_fault_o(boot_to[1])
    );
    bfd_phase u_phb (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .cmd_i(b_cmd),
        .boot_ok_i(b_ok[0]),
        .boot_low_i(b_low[0]),
        .enable_i(enable),
        .dead_on_i(dead_on),
        .dead_cyc_i(dead_cyc),
        .gate_o(phase_b_gate_o),
        .boot_fault_o(boot_to[0])
    );

    // open-drain fault pin: drive low only while faulted
    assign fault_n_o = 1'b0;
    assign fault_n_oe_o = ~st_r.fault_n;
    assign sleep_o = st_r.sleep;
endmodule

/* rtl/bfd_defs.svh */
// timing and field constants for the bridge fault and dead-time block
`ifndef BFD_DEFS_SVH
`define BFD_DEFS_SVH
`define BFD_CLK_NS 40
`define BFD_DEAD_MAX_NS 6000
`define BFD_DEAD_MAX_CYC ((`BFD_DEAD_MAX_NS + `BFD_CLK_NS - 1) / `BFD_CLK_NS)
`define BFD_CHARGE_TO_US 200
`define BFD_CHARGE_TO_CYC ((`BFD_CHARGE_TO_US * 1000) / `BFD_CLK_NS)
`define BFD_CLEAR_PULSE_NS 1000
`define BFD_CLEAR_CYC ((`BFD_CLEAR_PULSE_NS + `BFD_CLK_NS - 1) / `BFD_CLK_NS)
`define BFD_CP_WAKE_US 3
`define BFD_CP_WAKE_CYC ((`BFD_CP_WAKE_US * 1000) / `BFD_CLK_NS)
`define BFD_CNT_W 13
`define BFD_DSEL_OFF 2'h0
`define BFD_DSEL_EXT 2'h1
`define BFD_DSEL_MAX 2'h2
`endif

/* rtl/bfd_pkg.sv */
// types for the bridge fault and dead-time block
package bfd_pkg;
    typedef struct packed {
        logic high_side_cmd;
        logic low_side_cmd;
    } bfd_phase_cmd_t;
    typedef struct packed {
        logic high_gate_out;
        logic low_gate_out;
    } bfd_phase_gate_t;
    typedef enum logic [1:0] {
        BFD_IDLE,
        BFD_CHARGE,
        BFD_DEAD,
        BFD_HIGH
    } bfd_hs_state_t;
endpackage

/* rtl/bfd_sync2.sv */
// two-flop synchroniser for asynchronous levels
`timescale 1ns/10ps
module bfd_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } bfd_sync_st_t;
    bfd_sync_st_t st_r;
    bfd_sync_st_t st_nxt;
    always_comb begin
        st_nxt.s1 = async_i;
        st_nxt.s2 = st_r.s1;
    end
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign sync_o = st_r.s2;
endmodule

/* rtl/bfd_phase.sv */
// one bridge phase: lockout, dead interval and bootstrap charge cycles
`timescale 1ns/10ps
`include "bfd_defs.svh"
module bfd_phase (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input bfd_pkg::bfd_phase_cmd_t cmd_i,
    input wire logic boot_ok_i,
    input wire logic boot_low_i,
    input wire logic enable_i,
    input wire logic dead_on_i,
    input wire logic [`BFD_CNT_W-1:0] dead_cyc_i,
    output bfd_pkg::bfd_phase_gate_t gate_o,
    output logic boot_fault_o
);
    import bfd_pkg::*;
    typedef struct packed {
        bfd_hs_state_t hs;
        logic [`BFD_CNT_W-1:0] cnt;
        logic [`BFD_CNT_W-1:0] hs_off_age;
        logic [`BFD_CNT_W-1:0] ls_off_age;
        logic lo_dead;
        logic lo_q;
        logic timeout;
    } bfd_ph_st_t;
    bfd_ph_st_t st_r;
    bfd_ph_st_t st_nxt;
    logic hi_want;
    logic lo_want;
    logic hi_drv;
    logic lo_drv;
    always_comb begin
        st_nxt = st_r;
        st_nxt.timeout = 1'b0;
        // both high: low side wins
        hi_want = cmd_i.high_side_cmd & ~cmd_i.low_side_cmd & enable_i;
        lo_want = cmd_i.low_side_cmd & enable_i;
        hi_drv = 1'b0;
        lo_drv = 1'b0;
        case (st_r.hs)
            BFD_IDLE: begin
                st_nxt.cnt = '0;
                if (hi_want) begin
                    if (!boot_ok_i) begin
                        st_nxt.hs = BFD_CHARGE;
                    end else if (dead_on_i && st_r.ls_off_age < dead_cyc_i) begin
                        st_nxt.hs = BFD_DEAD;
                    end else begin
                        st_nxt.hs = BFD_HIGH;
                    end
                end
            end
            BFD_CHARGE: begin
                lo_drv = 1'b1;
                st_nxt.cnt = st_r.cnt + 1'b1;
                if (!hi_want) begin
                    st_nxt.hs = BFD_IDLE;
                end else if (boot_ok_i) begin
                    // charge until threshold plus hysteresis
                    st_nxt.hs = dead_on_i ? BFD_DEAD : BFD_HIGH;
                    st_nxt.cnt = '0;
                end else if (st_r.cnt >= `BFD_CNT_W'(`BFD_CHARGE_TO_CYC - 1)) begin
                    st_nxt.timeout = 1'b1;
                    st_nxt.hs = BFD_IDLE;
                end
            end
            BFD_DEAD: begin
                st_nxt.cnt = st_r.cnt + 1'b1;
                if (!hi_want) begin
                    st_nxt.hs = BFD_IDLE;
                end else if (st_r.cnt + 1'b1 >= dead_cyc_i) begin
                    st_nxt.hs = BFD_HIGH;
                end
            end
            BFD_HIGH: begin
                hi_drv = 1'b1;
                st_nxt.cnt = '0;
                if (!hi_want) begin
                    st_nxt.hs = BFD_IDLE;
                end else if (boot_low_i) begin
                    st_nxt.hs = BFD_CHARGE;
                end
            end
            default: st_nxt.hs = BFD_IDLE;
        endcase
        // low side: dead interval only if high side went off recently
        if (lo_want && st_r.hs != BFD_HIGH && !hi_drv) begin
            // hold off until the high side has been off long enough
            st_nxt.lo_dead = dead_on_i && !st_r.lo_q
                             && st_r.hs_off_age < dead_cyc_i;
            if (!st_nxt.lo_dead) begin
                lo_drv = 1'b1;
            end
        end else begin
            st_nxt.lo_dead = 1'b0;
        end
        if (st_r.hs == BFD_HIGH && st_nxt.hs != BFD_HIGH) begin
            st_nxt.hs_off_age = '0;
        end else if (st_r.hs_off_age != '1) begin
            st_nxt.hs_off_age = st_r.hs_off_age + 1'b1;
        end
        // age stays zero while the low gate is on, so it counts from turn-off
        if (st_r.lo_q) begin
            st_nxt.ls_off_age = '0;
        end else if (st_r.ls_off_age != '1) begin
            st_nxt.ls_off_age = st_r.ls_off_age + 1'b1;
        end
        st_nxt.lo_q = lo_drv;
        if (!enable_i) begin
            // outputs disabled: all gates low
            st_nxt.hs = BFD_IDLE;
            st_nxt.lo_q = 1'b0;
            st_nxt.lo_dead = 1'b0;
        end
    end
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= '{hs: BFD_IDLE, cnt: '0, hs_off_age: '1,
                      ls_off_age: '1, default: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end
    // register each gate so the top drives them straight from flops
    logic hi_q_r;
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            hi_q_r <= 1'b0;
        end else begin
            hi_q_r <= (st_nxt.hs == BFD_HIGH) & enable_i;
        end
    end
    assign gate_o.high_gate_out = hi_q_r;
    assign gate_o.low_gate_out = st_r.lo_q;
    assign boot_fault_o = st_r.timeout;
endmodule

/* sim/bfd_ctrl_model.sv */
// controller model driving the four side commands
`timescale 1ns/10ps
module bfd_ctrl_model (
    input wire logic clk_sys_i,
    input wire logic dead_off_i,
    output bfd_pkg::bfd_phase_cmd_t phase_a_cmd_o,
    output bfd_pkg::bfd_phase_cmd_t phase_b_cmd_o
);
    import bfd_pkg::*;
    // ------------------------------------------------------------
    // command sequencing
    // ------------------------------------------------------------
    // gap well beyond sync and gate latency; model has no tuning
    localparam int GAP = 8;
    initial begin
        phase_a_cmd_o = '0;
        phase_b_cmd_o = '0;
    end
    // cmd is {a_high, a_low, b_high, b_low}
    task automatic drive(input logic [3:0] cmd);
        logic [3:0] now;
        now = {phase_a_cmd_o, phase_b_cmd_o};
        if (dead_off_i && ((now & ~cmd) != 4'h0)) begin
            @(posedge clk_sys_i);
            #2;
            {phase_a_cmd_o, phase_b_cmd_o} = now & cmd;
            repeat (GAP) @(posedge clk_sys_i);
        end
        @(posedge clk_sys_i);
        #2;
        {phase_a_cmd_o, phase_b_cmd_o} = cmd;
    endtask
endmodule

/* sim/bfd_top_monitor.sv */
// concurrent checks on the ports of the bridge fault block
`timescale 1ns/10ps
module bfd_mon (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic sleep_clear_n_i,
    input wire logic overtemp_i,
    input wire logic gate_supply_below_falling_i,
    input wire logic gate_supply_above_rising_i,
    input wire logic logic_supply_low_i,
    input bfd_pkg::bfd_phase_gate_t phase_a_gate_o,
    input bfd_pkg::bfd_phase_gate_t phase_b_gate_o,
    input wire logic fault_n_oe_o
);
    import bfd_pkg::*;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    wire logic gates_off = ({phase_a_gate_o, phase_b_gate_o} == 4'h0);
    // ------------------------------------------------------------
    // sequences and assertions
    // ------------------------------------------------------------
    // five cycles cover the two-flop sync plus the output register
    sequence s_asleep;
        !sleep_clear_n_i [*5];
    endsequence
    sequence s_uv_hold;
        gate_supply_below_falling_i ##1
            (!gate_supply_above_rising_i && sleep_clear_n_i) [*6];
    endsequence
    lock_a_a: assert property (
        phase_a_gate_o.high_gate_out |-> !phase_a_gate_o.low_gate_out)
        else $error("phase a gates both on");
    lock_b_a: assert property (
        phase_b_gate_o.high_gate_out |-> !phase_b_gate_o.low_gate_out)
        else $error("phase b gates both on");
    sleep_off_a: assert property (
        s_asleep |-> gates_off)
        else $error("gates on while asleep");
    wake_hold_a: assert property (
        $rose(sleep_clear_n_i) |=> gates_off [*8])
        else $error("gates on right after wake");
    vdd_fault_a: assert property (
        logic_supply_low_i [*5] |-> fault_n_oe_o && gates_off)
        else $error("logic supply fault not shown");
    gate_regulator_supply_fault_a: assert property (
        gate_supply_below_falling_i [*5] |-> fault_n_oe_o && gates_off)
        else $error("gate supply fault not shown");
    gate_regulator_supply_hold_a: assert property (
        s_uv_hold |-> fault_n_oe_o)
        else $error("gate supply fault left early");
    ot_fault_a: assert property (
        overtemp_i [*5] |-> fault_n_oe_o)
        else $error("overtemperature not shown");
endmodule
bind bfd_top bfd_mon mon_u (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .sleep_clear_n_i(sleep_clear_n_i),
    .overtemp_i(overtemp_i),
    .gate_supply_below_falling_i(gate_supply_below_falling_i),
    .gate_supply_above_rising_i(gate_supply_above_rising_i),
    .logic_supply_low_i(logic_supply_low_i),
    .phase_a_gate_o(phase_a_gate_o),
    .phase_b_gate_o(phase_b_gate_o),
    .fault_n_oe_o(fault_n_oe_o)
);

/* sim/bfd_top_tb.sv */
// self-checking bench for the bridge fault and dead-time block
`timescale 1ns/10ps
`include "bfd_defs.svh"
module bfd_top_tb;
    import bfd_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic sleep_n = 1'b1;
    logic otemp = 1'b0;
    logic below = 1'b0;
    logic above = 1'b1;
    logic vdd_low = 1'b0;
    logic [1:0] boot_ok = 2'h3;
    logic [1:0] boot_low = 2'h0;
    logic pump = 1'b1;
    logic [1:0] dsel = `BFD_DSEL_OFF;
    logic [`BFD_CNT_W-1:0] ext_cyc = 13'h14;
    bfd_phase_cmd_t a_cmd;
    bfd_phase_cmd_t b_cmd;
    bfd_phase_gate_t a_gate;
    bfd_phase_gate_t b_gate;
    logic oe;
    logic fault_pin;
    logic sleep_st;
    wire logic [3:0] g = {a_gate, b_gate};
    int n_mismatch = 0;
    int num_checks = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    bfd_top dut_u (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .phase_a_cmd_i(a_cmd),
        .phase_b_cmd_i(b_cmd),
        .sleep_clear_n_i(sleep_n),
        .overtemp_i(otemp),
        .gate_supply_below_falling_i(below),
        .gate_supply_above_rising_i(above),
        .logic_supply_low_i(vdd_low),
        .boot_ok_i(boot_ok),
        .boot_low_i(boot_low),
        .charge_pump_ready_i(pump),
        .dead_interval_select_i(dsel),
        .dead_ext_cyc_i(ext_cyc),
        .phase_a_gate_o(a_gate),
        .phase_b_gate_o(b_gate),
        .fault_n_o(fault_pin),
        .fault_n_oe_o(oe),
        .sleep_o(sleep_st)
    );
    bfd_ctrl_model ctrl_u (
        .clk_sys_i(clk_sys_i),
        .dead_off_i(dsel == `BFD_DSEL_OFF),
        .phase_a_cmd_o(a_cmd),
        .phase_b_cmd_o(b_cmd)
    );
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys_i);
        #2;
    endtask
    task automatic chk(input string nm, input logic [3:0] e,
                       input logic [3:0] got);
        num_checks++;
        if (got !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, got);
        end
    endtask
    task automatic step(input logic [3:0] c, input int n,
                        input logic [3:0] e, input string nm);
        ctrl_u.drive(c);
        w(n);
        chk(nm, e, g);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // about 11100 cycles expected; generous margin
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_mismatch++;
        give_verdict;
    end
    initial begin
        w(10);
        reset_i = 1'b0;
        w(5);
        chk("oe_powerup", 4'h1, {3'h0, oe});
        chk("fault_pin", 4'h0, {3'h0, fault_pin});
        pump = 1'b0;
        sleep_n = 1'b0;
        w(30);
        chk("sleep", 4'h1, {3'h0, sleep_st});
        ctrl_u.drive(4'h8);
        sleep_n = 1'b1;
        w(120);
        chk("gates_wake", 4'h0, g);
        chk("oe_cleared", 4'h0, {3'h0, oe});
        pump = 1'b1;
        w(90);
        chk("a_high", 4'h8, g);
        step(4'hc, 5, 4'h4, "a_both");
        step(4'h5, 30, 4'h5, "brake_low");
        step(4'ha, 30, 4'ha, "brake_high");
        dsel = `BFD_DSEL_EXT;
        step(4'h5, 30, 4'h5, "lows");
        step(4'ha, 10, 4'h0, "dead_ext");
        w(20);
        chk("after_ext", 4'ha, g);
        dsel = `BFD_DSEL_MAX;
        step(4'h5, 200, 4'h5, "lows2");
        step(4'ha, 100, 4'h0, "dead_max");
        w(60);
        chk("after_max", 4'ha, g);
        dsel = `BFD_DSEL_EXT;
        step(4'h0, 50, 4'h0, "all_off");
        step(4'h8, 5, 4'h8, "no_dead");
        boot_ok = 2'h1;
        boot_low = 2'h2;
        w(6);
        chk("recharge", 4'h4, g);
        boot_ok = 2'h3;
        boot_low = 2'h0;
        w(10);
        chk("charge_dead", 4'h0, g);
        w(25);
        chk("charge_done", 4'h8, g);
        otemp = 1'b1;
        w(6);
        chk("ot_oe", 4'h1, {3'h0, oe});
        chk("ot_gates", 4'h8, g);
        otemp = 1'b0;
        w(6);
        chk("ot_clear", 4'h0, {3'h0, oe});
        below = 1'b1;
        above = 1'b0;
        w(6);
        chk("uv_oe", 4'h1, {3'h0, oe});
        chk("uv_gates", 4'h0, g);
        below = 1'b0;
        w(10);
        chk("uv_latched", 4'h1, {3'h0, oe});
        above = 1'b1;
        ctrl_u.drive(4'h0);
        ctrl_u.drive(4'h8);
        w(10);
        chk("uv_edge_clr", 4'h0, {3'h0, oe});
        step(4'h0, 5, 4'h0, "off");
        boot_ok = 2'h1;
        step(4'h8, 6, 4'h4, "charge");
        w(5010);
        chk("boot_oe", 4'h1, {3'h0, oe});
        chk("boot_gates", 4'h0, g);
        vdd_low = 1'b1;
        w(6);
        chk("vdd_oe", 4'h1, {3'h0, oe});
        vdd_low = 1'b0;
        w(6);
        chk("vdd_clear", 4'h0, {3'h0, oe});
        ctrl_u.drive(4'h0);
        step(4'h8, 5020, 4'h0, "boot_fault2");
        chk("boot_oe2", 4'h1, {3'h0, oe});
        sleep_n = 1'b0;
        w(3);
        boot_ok = 2'h3;
        sleep_n = 1'b1;
        w(10);
        chk("boot_clear", 4'h0, {3'h0, oe});
        w(100);
        chk("resume", 4'h8, g);
        give_verdict;
    end
endmodule
